// [ctp_pwm_timebase.sv]
// Contract
// - Period comes from the writable period limit, compared each increment.
// - After count equals limit, next increment clears count and loads duty.
// - Pin goes high at each restart unless duty value is zero.
// - Postscale select does not affect the PWM period.
// - Duty is 10 bits: buffer byte plus channel control bits 5:4.
// - Duty writes accepted anytime, effective only after next period match.
// - Active duty register is read only; writes leave it unchanged.
// - Active duty byte plus hidden 2-bit latch double-buffer the duty.
// - Pin clears when active duty equals count extended by prescale bits.
// - Duty beyond period never matches, pin stays high all period.
// - Prescaler divides by 1, 4 or 16 via two-bit select.
// - Timebase control: postscale 6:3, run 2, prescale 1:0, bit 7 zero.
// - Channel control: bits 7:6 read zero, 5:4 duty low, 3:0 mode.
// - Usable duty resolution is log2 of clock over PWM frequency.
// - Writing zero to channel control forces the output latch low.
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
module ctp_pwm_timebase
  import ctp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // PWM pin
  output logic             PWM_OUT
);
  // ==========================================
  // Extra registers beyond the first four offsets
  localparam logic [3:0] ADDR_DUTYACT = 4'h0;
  localparam logic [3:0] ADDR_CHCTRL  = 4'h4;

  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  period;
    logic [7:0]  tbctrl;
    logic [7:0]  dutybuf;
    logic [7:0]  dutyact;
    logic [1:0]  dutylat;
    logic [7:0]  chctrl;
    logic        matched;
    logic        pin;
    logic        restart;
    logic        ack;
    logic [31:0] rdata;
  } ctp_state_t;

  ctp_state_t r;
  ctp_state_t next_r;

  // ==========================================
  // Address decode: bank chosen by the byte lane selects
  logic       bank;
  logic [3:0] adr;
  logic       req;
  logic       wr;
  logic       pwm_on;
  logic       tick;
  logic [1:0] phase;
  logic [9:0] duty_act;
  logic [9:0] cmp_val;

  // Extended address: port is 4 bits, bank chosen by byte lane 3 select
  assign adr  = WB_ADR_I;
  assign bank = WB_SEL_I[3] && !WB_SEL_I[0];
  assign req  = WB_CYC_I && WB_STB_I && !r.ack;
  // Bank 1 writes come on lane 3, otherwise the mode could never be set
  assign wr   = req && WB_WE_I && (WB_SEL_I[0] || bank);

  assign pwm_on = (r.chctrl[CH_MODE_LSB +: 4] == MODE_PWM)
                  && r.tbctrl[TB_RUN_BIT];

  // only prescale bits reach the divider select
  ctp_prescaler u_pre (
    .clk   (CLK_SYS),
    .rst   (RST),
    .ce    (CE),
    .run   (pwm_on),
    .sel   (r.tbctrl[TB_PRE_LSB +: 2]),
    .tick  (tick),
    .phase (phase)
  );

  assign duty_act = {r.dutyact, r.dutylat};
  assign cmp_val  = {r.count, phase};

  function automatic logic [7:0] rd_mux(input logic b, input logic [3:0] a,
                                        input ctp_state_t s);
    if (b) begin
      unique case (a)
        ADDR_DUTYACT: rd_mux = s.dutyact;
        ADDR_CHCTRL:  rd_mux = s.chctrl & CHCTRL_MASK;
        default:      rd_mux = 8'h00;
      endcase
    end else begin
      unique case (a)
        ADDR_COUNT:   rd_mux = s.count;
        ADDR_PERIOD:  rd_mux = s.period;
        ADDR_TBCTRL:  rd_mux = s.tbctrl & TBCTRL_MASK;
        default:      rd_mux = s.dutybuf;
      endcase
    end
  endfunction

  always_comb begin
    next_r = r;
    next_r.ack = req;
    next_r.rdata = {24'h000000, rd_mux(bank, adr, r)};

    // ==========================================
    // Timebase and compare
    if (pwm_on) begin
      next_r.restart = 1'b0;
      // Rise one cycle late, matching the registered clear path
      if (r.restart && duty_act != 10'h000)
        next_r.pin = 1'b1;
      // Compare against period limit each increment
      if (tick) begin
        if (r.matched) begin
          next_r.count   = 8'h00;
          next_r.matched = 1'b0;
          next_r.restart = 1'b1;
          next_r.dutyact = r.dutybuf;
          next_r.dutylat = r.chctrl[CH_DLSB_LSB +: 2];
          // Zero duty keeps the pin low
          if ({r.dutybuf, r.chctrl[CH_DLSB_LSB +: 2]} == 10'h000)
            next_r.pin = 1'b0;
        end else begin
          next_r.count   = r.count + 8'h01;
          next_r.matched = (r.count + 8'h01) == r.period;
        end
      end
      // Duty past the period simply never matches
      if (duty_act == cmp_val)
        next_r.pin = 1'b0;
    end else begin
      next_r.matched = (r.count == r.period);
      next_r.restart = 1'b0;
    end

    // ==========================================
    // Register writes
    if (wr) begin
      if (bank) begin
        if (adr == ADDR_CHCTRL) begin
          next_r.chctrl = WB_DAT_I[7:0] & CHCTRL_MASK;
          if (WB_DAT_I[7:0] == 8'h00)
            next_r.pin = 1'b0;
        end
        // Active duty write is dropped
      end else begin
        unique case (adr)
          ADDR_COUNT: begin
            next_r.count   = WB_DAT_I[7:0];
            next_r.matched = WB_DAT_I[7:0] == r.period;
          end
          ADDR_PERIOD:  next_r.period  = WB_DAT_I[7:0];
          ADDR_TBCTRL:  next_r.tbctrl  = WB_DAT_I[7:0] & TBCTRL_MASK;
          default:      next_r.dutybuf = WB_DAT_I[7:0];
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      r        <= '0;
      r.period <= PERIOD_RST;
    end else if (CE) begin
      r <= next_r;
    end
  end

  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.rdata;
  assign PWM_OUT  = r.pin;

  // ==========================================
  // Checks: timebase and restart
  chk_restart_clears: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && r.matched && !wr |=> r.count == 8'h00)
    else $error("count not cleared after period match");
  chk_restart_flag: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && r.matched && !wr |=> r.restart)
    else $error("restart not flagged after period match");
  chk_count_step: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && !r.matched && !wr
    |=> r.count == $past(r.count) + 8'h01)
    else $error("count did not advance on tick");
  chk_match_flag: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && !r.matched && !wr
    |=> r.matched == (r.count == r.period))
    else $error("period match flag wrong");
  chk_count_hold: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && !tick && !wr |=> $stable(r.count))
    else $error("count moved between ticks");
  chk_hold_off: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && !pwm_on && !wr |=> $stable(r.count))
    else $error("count moved while disabled");
  chk_ce_freeze: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    !CE |=> $stable(r))
    else $error("state moved with clock enable low");

  // ==========================================
  // Checks: prescaler
  chk_pre_div1: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    pwm_on && r.tbctrl[TB_PRE_LSB +: 2] == PRE_DIV1
    |-> tick && phase == 2'h0)
    else $error("divide by one not ticking every cycle");
  chk_pre_gap: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && !wr
    && r.tbctrl[TB_PRE_LSB +: 2] != PRE_DIV1 |=> !tick)
    else $error("prescaler ticked twice in a row");

  // ==========================================
  // Checks: duty double buffer and register writes
  chk_duty_load: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && r.matched && !wr
    |=> r.dutyact == $past(r.dutybuf))
    else $error("duty not loaded at restart");
  chk_lat_load: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && r.matched && !wr
    |=> r.dutylat == $past(r.chctrl[CH_DLSB_LSB +: 2]))
    else $error("duty low bits not latched at restart");
  chk_lat_hold: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && !(pwm_on && tick && r.matched) |=> $stable(r.dutylat))
    else $error("duty low latch changed outside restart");
  chk_act_readonly: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && !(pwm_on && tick && r.matched) |=> $stable(r.dutyact))
    else $error("active duty changed outside restart");
  chk_dutybuf_wr: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && wr && !bank && adr == ADDR_DUTYBUF
    |=> r.dutybuf == $past(WB_DAT_I[7:0]))
    else $error("duty buffer write lost");
  chk_period_wr: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && wr && !bank && adr == ADDR_PERIOD
    |=> r.period == $past(WB_DAT_I[7:0]))
    else $error("period limit write lost");
  chk_chctrl_wr: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && wr && bank && adr == ADDR_CHCTRL
    |=> r.chctrl == ($past(WB_DAT_I[7:0]) & CHCTRL_MASK))
    else $error("channel control write lost");

  // ==========================================
  // Checks: output pin
  chk_zero_duty_low: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && tick && r.matched && !wr
    && {r.dutybuf, r.chctrl[CH_DLSB_LSB +: 2]} == 10'h000 |=> !PWM_OUT)
    else $error("pin set with zero duty");
  chk_restart_high: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && r.restart && !wr && duty_act != 10'h000
    && duty_act != cmp_val && !(tick && r.matched) |=> PWM_OUT)
    else $error("pin not set after restart");
  chk_pin_clear: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && duty_act == cmp_val |=> !PWM_OUT)
    else $error("pin not cleared at duty match");
  chk_overrun_high: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && pwm_on && PWM_OUT && duty_act != cmp_val
    && !(tick && r.matched) && !wr |=> PWM_OUT)
    else $error("pin dropped without duty match");
  chk_chctrl_zero: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && wr && bank && adr == ADDR_CHCTRL && WB_DAT_I[7:0] == 8'h00
    |=> !PWM_OUT)
    else $error("pin not forced low");
  chk_off_pin: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && !pwm_on && !PWM_OUT |=> !PWM_OUT)
    else $error("pin rose while disabled");

  // ==========================================
  // Checks: register bus
  chk_tbctrl_top: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (r.tbctrl & ~TBCTRL_MASK) == 8'h00)
    else $error("timebase control top bit set");
  chk_chctrl_top: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (r.chctrl & ~CHCTRL_MASK) == 8'h00)
    else $error("channel control top bits set");
  chk_rd_active: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && req && !WB_WE_I && bank && adr == ADDR_DUTYACT
    |=> WB_DAT_O[7:0] == $past(r.dutyact))
    else $error("active duty read wrong");
  chk_rd_upper: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && req |=> WB_DAT_O[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_ack_one: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not single cycle");
  chk_ack_idle: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    CE && !WB_CYC_I |=> !WB_ACK_O)
    else $error("ack without a cycle");
endmodule // ctp_pwm_timebase

// [ctp_pkg.sv]
package ctp_pkg;
  // ==========================================
  // Register byte addresses (word aligned)
  localparam logic [3:0] ADDR_COUNT   = 4'h0;
  localparam logic [3:0] ADDR_PERIOD  = 4'h4;
  localparam logic [3:0] ADDR_TBCTRL  = 4'h8;
  localparam logic [3:0] ADDR_DUTYBUF = 4'hc;
  localparam int         ADDR_W       = 4;
  // ==========================================
  // Field positions
  localparam int TB_RUN_BIT   = 2;
  localparam int TB_PRE_LSB   = 0;
  localparam int TB_POST_LSB  = 3;
  localparam int CH_DLSB_LSB  = 4;
  localparam int CH_MODE_LSB  = 0;
  // ==========================================
  // Reset values and encodings
  localparam logic [7:0] PERIOD_RST   = 8'hff;
  localparam logic [7:0] TBCTRL_MASK  = 8'h7f;
  localparam logic [7:0] CHCTRL_MASK  = 8'h3f;
  localparam logic [3:0] MODE_PWM     = 4'hc;
  localparam logic [1:0] PRE_DIV1     = 2'h0;
  localparam logic [1:0] PRE_DIV4     = 2'h1;
  localparam logic [3:0] PRE_LAST4    = 4'h3;
  localparam logic [3:0] PRE_LAST16   = 4'hf;
endpackage

// [ctp_prescaler.sv]
// ==========================================
// Timebase prescaler: tick every 1, 4 or 16 enabled cycles
module ctp_prescaler
  import ctp_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Result
  output logic            tick,
  output logic      [1:0] phase
);
  typedef struct packed {
    logic [3:0] cnt;
  } ctp_pre_t;

  ctp_pre_t r;
  ctp_pre_t next_r;
  logic [3:0] last;

  always_comb begin
    next_r = r;
    unique case (sel)
      PRE_DIV1: last = 4'h0;
      PRE_DIV4: last = PRE_LAST4;
      default:  last = PRE_LAST16;
    endcase
    if (!run)
      next_r.cnt = 4'h0;
    else if (r.cnt >= last)
      next_r.cnt = 4'h0;
    else
      next_r.cnt = r.cnt + 4'h1;
  end

  assign tick = run && (r.cnt >= last);
  // Two sub-count bits extend the 8-bit compare to 10 bits
  assign phase = (sel == PRE_DIV1) ? 2'h0 :
                 (sel == PRE_DIV4) ? r.cnt[1:0] : r.cnt[3:2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      r <= '0;
    else if (ce)
      r <= next_r;
  end
endmodule // ctp_prescaler

// [ctp_load.sv]
// ====
// Load on the pin: measures period and high time
module ctp_load (
  // Clock and pin
  input  wire logic clk,
  input  wire logic pin,
  // Measurements
  output int        n_rise,
  output int        per,
  output int        hi
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc;
  int   hcnt;
  logic last;
  initial begin
    {n_rise, per, hi, cyc, hcnt} = '0;
    last = 1'b0;
  end
  // Only a rise closes a pulse: a pin stuck high reports nothing
  always @(posedge clk) begin
    if (pin === 1'b1 && last !== 1'b1) begin
      n_rise <= n_rise + 1;
      per <= cyc;
      hi <= hcnt;
      cyc = 1;
      hcnt = 1;
    end else begin
      cyc = cyc + 1;
      hcnt = hcnt + (pin === 1'b1);
    end
    last = pin;
  end
endmodule // ctp_load

// [ctp_pwm_timebase_test.sv]
module ctp_pwm_timebase_test
  import ctp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, ce, cyc, stb, we, ack, pwm;
  logic [3:0]  adr, sel;
  logic [31:0] dat, dat_o, q;
  int          fail_count, n_checks, seed, p, d, e, n_rise, per, hi, cnt;
  logic [3:0]  ta [7] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h0, 4'h4, 4'h8};
  ctp_pwm_timebase uut (.CLK_SYS(clk), .RST(rst), .CE(ce), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(sel), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PWM_OUT(pwm));
  ctp_load load (.clk(clk), .pin(pwm), .n_rise(n_rise), .per(per), .hi(hi));
  always #2 clk = ~clk;
  // ====
  // Bus and compare tasks
  task automatic bus(input logic w, input logic [3:0] a, s,
                     input logic [7:0] v);
    int n = 0;
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, 24'h0, v};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) fail_count++;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask
  task automatic chk_reg(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_meas(input int got, exp);
    n_checks++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH %0t meas got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, s, input logic [7:0] x);
    bus(1'b0, a, s, 8'h00);
    chk_reg(q, {24'h0, x});
  endtask
  task automatic wait_rise(input int k);
    int t0 = n_rise;
    repeat (20000) if (n_rise < t0 + k) @(posedge clk);
    chk_meas(n_rise, t0 + k);
  endtask
  task automatic setup(input logic [1:0] pre, input logic [3:0] post);
    bus(1'b1, ADDR_PERIOD, 4'h1, p[7:0]);
    bus(1'b1, ADDR_COUNT, 4'h1, 8'h00);
    bus(1'b1, ADDR_DUTYBUF, 4'h1, d[9:2]);
    bus(1'b1, 4'h4, 4'h8, {2'b00, d[1:0], 4'h0});
    bus(1'b1, ADDR_TBCTRL, 4'h1, {1'b0, post, 1'b1, pre});
    bus(1'b1, 4'h4, 4'h8, {2'b00, d[1:0], MODE_PWM});
  endtask
  task automatic off;
    bus(1'b1, 4'h4, 4'h8, 8'h00);
    bus(1'b1, ADDR_TBCTRL, 4'h1, 8'h00);
    chk_reg({31'h0, pwm}, 32'h0);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test;
  end
  // ====
  // Scenarios
  initial begin
    seed = 32'h04ba6267;
    {clk, cyc, stb, we, adr, sel, dat, fail_count, n_checks} = '0;
    {rst, ce} = 2'b11;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd(ta[i], (i < 4) ? 4'h1 : 4'h8, (i == 1) ? PERIOD_RST : 8'h00);
    end
    $display("test reset done");
    bus(1'b1, ADDR_TBCTRL, 4'h1, 8'hff);
    rd(ADDR_TBCTRL, 4'h1, TBCTRL_MASK);
    bus(1'b1, 4'h4, 4'h8, 8'hff);
    rd(4'h4, 4'h8, CHCTRL_MASK);
    rd(ADDR_COUNT, 4'h1, 8'h00);
    bus(1'b1, 4'h0, 4'h8, 8'h5a);
    rd(4'h0, 4'h8, 8'h00);
    off;
    $display("test fields done");
    for (int k = 0; k < 3; k++) begin
      p = 8 + ($random(seed) & 7);
      // Divide by one has no sub-count bits: keep duty on a step of four
      d = (k == 0) ? 4 * (1 + ($random(seed) & 7))
                   : 1 + ($random(seed) & 31);
      setup(k[1:0], 4'($random(seed)));
      wait_rise(3);
      e = (k == 0) ? p + 1 : (k == 1) ? 4 * (p + 1) : 16 * (p + 1);
      chk_meas(per, e);
      if (k > 0) chk_meas(hi, (k == 1) ? d : 4 * d);
      if (k == 0) begin
        cnt = n_rise;
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        chk_meas(n_rise, cnt);
        ce <= 1'b1;
        @(posedge clk);
      end
      if (k == 2) begin
        wait_rise(1);
        bus(1'b1, ADDR_DUTYBUF, 4'h1, d[9:2] + 8'h01);
        rd(4'h0, 4'h8, d[9:2]);
        wait_rise(1);
        rd(4'h0, 4'h8, d[9:2] + 8'h01);
      end
      off;
    end
    $display("test pwm done");
    for (int j = 0; j < 2; j++) begin
      p = 8;
      d = j ? 4 * (p + 1) + 4 : 0;
      setup(PRE_DIV1, 4'h0);
      if (j) wait_rise(1);
      cnt = 0;
      repeat (3 * (p + 1)) begin
        @(posedge clk);
        cnt += (pwm !== j[0]);
      end
      chk_meas(cnt, 0);
      off;
    end
    $display("test limits done");
    stop_test;
  end
endmodule // ctp_pwm_timebase_test
